// ---- core/fault_supervisor_consts.vh ----
// Purpose: Shared constants of the high-side fault supervisor.
// Assumes: 125 MHz aclk, AXI4-Lite register access with 32-bit data.
// Notes: Definitions only.
`ifndef FAULT_SUPERVISOR_CONSTS_VH
`define FAULT_SUPERVISOR_CONSTS_VH

// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_PERIOD_NS 8
`define DEGLITCH_NS 3000
`define DEGLITCH_CYC 16'h0177
`define RETRY_CYC_DEF 16'h0FA0
`define FOLD_LIMIT 4'h7
`define TIMER_W 16

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define OFS_CTRL 5'h00
`define OFS_STATUS 5'h04
`define OFS_IRQ_STAT 5'h08
`define OFS_IRQ_CLR 5'h0C
`define OFS_IRQ_EN 5'h10
`define ADDR_W 5

// ----------------------------------------
// Fields
// ----------------------------------------
`define CTRL_FOLD_EN 0
`define ST_FAULT 0
`define ST_ABS 1
`define ST_REL 2
`define ST_OC 3
`define ST_ON 4
`define ST_HALF 5
`define ST_UV 6
`define ST_INT 7
`define ST_CNT_LO 8
`define ST_CNT_HI 11
`define IRQ_W 4
`define IRQ_FAULT 0
`define IRQ_RELEASE 1
`define IRQ_UV 2
`define IRQ_FOLD 3

// ----------------------------------------
// Bus answers and reset values
// ----------------------------------------
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`define CTRL_RST 1'h0
`define IRQ_RST 4'h0
`define CNT_RST 4'h0
`define DATA_ZERO 32'h00000000

`endif

// ---- core/event_timer.v ----
// Purpose: Counts cycles while run is high and flags when the limit is reached.
// Assumes: Synchronous active-low reset.
// Notes: Dropping run restarts the count.
`timescale 1ns/10ps
`include "fault_supervisor_consts.vh"

module event_timer #(
	parameter [`TIMER_W-1:0] LIMIT = 16'h0001
) (
	// Clock and reset
	input wire aclk,
	input wire aresetn,
	// Control
	input wire run,
	output wire done
);

	reg [`TIMER_W-1:0] cnt_r;

	assign done = (cnt_r == LIMIT);

	always @(posedge aclk) begin
		if (!aresetn) begin
			cnt_r <= 16'h0000;
		end else if (!run) begin
			cnt_r <= 16'h0000;
		end else if (cnt_r != LIMIT) begin
			cnt_r <= cnt_r + 16'h0001;
		end
	end

endmodule // event_timer

// ---- core/high_side_fault_supervisor.v ----
// What this block does
// R01: Thermal or current fault switches off, enters fault.
// R02: Release needs latch low, retry expired, faults gone.
// R03: Thermal fault on absolute or relative over-temperature.
// R04: Absolute fault clears only below hysteresis point.
// R05: Relative fault clears after retry interval.
// R06: Current limit reached turns channel off immediately; the code turns it off one cycle after the deglitch time.
// R07: Fault state drives sense output fault level.
// R08: Over-current counts only after deglitch time.
// R09: Foldback variant halves limit after seven faults.
// R10: Foldback restores on standby or clean cycle.
// R11: Non-foldback variant never changes its limit.
// R12: Bad limit resistor selects internal limit.
// R13: Undervoltage locks output off until rise threshold.
// R14: Controller holds enable low during slow ramp.
// R15: Load dump keeps switch state unchanged.
// R16: Latch-select high holds switch off after fault.
// R17: Latch-select low retries automatically after clearing.
// R18: Retry, deglitch, foldback count are cycle parameters.
//
// Purpose: Fault supervision of a single-channel high-side switch with AXI4-Lite registers.
// Assumes: Analog comparators arrive as synchronous levels on aclk.
// Notes: Analog measurement itself stays outside this block.
//
// The AXI4-Lite interface to the registers and the address map are this design's own decisions.
`timescale 1ns/10ps
`include "fault_supervisor_consts.vh"

module high_side_fault_supervisor #(
	parameter [`TIMER_W-1:0] RETRY_CYCLES = `RETRY_CYC_DEF,
	parameter [`TIMER_W-1:0] DEGLITCH_CYCLES = `DEGLITCH_CYC,
	parameter [3:0] FOLD_COUNT = `FOLD_LIMIT
) (
	// Clock and reset
	input wire aclk,
	input wire aresetn,
	// Controller pins
	input wire enable_in,
	input wire latch_sel,
	input wire standby_in,
	// Comparator levels
	input wire fet_over_abs,
	input wire fet_below_hys,
	input wire rel_over,
	input wire over_current,
	input wire limit_set_resistor_ok,
	input wire undervoltage_fall_threshold,
	input wire undervoltage_rise_threshold,
	input wire load_dump,
	// Switch and sense control
	output wire switch_on,
	output wire sense_fault,
	output wire limit_half,
	output wire limit_internal,
	output wire irq,
	// AXI4-Lite write
	input wire [`ADDR_W-1:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output wire s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output wire s_axi_wready,
	output wire [1:0] s_axi_bresp,
	output wire s_axi_bvalid,
	input wire s_axi_bready,
	// AXI4-Lite read
	input wire [`ADDR_W-1:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output wire s_axi_arready,
	output wire [31:0] s_axi_rdata,
	output wire [1:0] s_axi_rresp,
	output wire s_axi_rvalid,
	input wire s_axi_rready
);

	// ----------------------------------------
	// States
	// ----------------------------------------
	localparam [3:0] S_OFF = 4'h1;
	localparam [3:0] S_ON = 4'h2;
	localparam [3:0] S_FAULT = 4'h4;
	localparam [3:0] S_LOCK = 4'h8;

	reg [3:0] state_r;
	reg [3:0] state_nxt;
	reg abs_flt_r;
	reg rel_flt_r;
	reg oc_flt_r;
	reg uv_lock_r;
	reg [3:0] fold_cnt_r;
	reg clean_r;
	reg half_r;
	reg int_lim_r;
	reg fold_en_r;
	reg [`IRQ_W-1:0] irq_stat_r;
	reg [`IRQ_W-1:0] irq_en_r;
	reg irq_r;
	reg aw_got_r;
	reg w_got_r;
	reg [`ADDR_W-1:0] awaddr_r;
	reg [31:0] wdata_r;
	reg [3:0] wstrb_r;
	reg awready_r;
	reg wready_r;
	reg bvalid_r;
	reg [1:0] bresp_r;
	reg arready_r;
	reg rvalid_r;
	reg [31:0] rdata_r;
	reg [1:0] rresp_r;
	reg [`IRQ_W-1:0] irq_ev;
	reg [`IRQ_W-1:0] irq_clr;
	reg [31:0] rd_mux;
	reg rd_ok;

	wire oc_seen;
	wire retry_done;
	wire faults_any;
	wire fault_entry;
	wire do_write;
	wire wr_ok;

	// ----------------------------------------
	// Timers
	// ----------------------------------------
	// The filter keeps switching spikes from tripping the limit.
	event_timer #(.LIMIT(DEGLITCH_CYCLES)) u_deglitch ( // R18
		.aclk(aclk),
		.aresetn(aresetn),
		.run(over_current), // R08
		.done(oc_seen)
	);

	event_timer #(.LIMIT(RETRY_CYCLES)) u_retry ( // R18
		.aclk(aclk),
		.aresetn(aresetn),
		.run(state_r == S_FAULT),
		.done(retry_done)
	);

	// ----------------------------------------
	// Fault flags
	// ----------------------------------------
	assign faults_any = abs_flt_r | rel_flt_r | oc_flt_r;
	assign fault_entry = (state_r != S_FAULT) && (state_nxt == S_FAULT);

	always @(posedge aclk) begin
		if (!aresetn) begin
			abs_flt_r <= 1'b0;
			rel_flt_r <= 1'b0;
			oc_flt_r <= 1'b0;
			uv_lock_r <= 1'b0;
			int_lim_r <= 1'b0;
		end else begin
			if (fet_over_abs) begin
				abs_flt_r <= 1'b1; // R03
			end else if (fet_below_hys) begin
				abs_flt_r <= 1'b0; // R04
			end
			if (rel_over && !rel_flt_r) begin
				rel_flt_r <= 1'b1; // R03
			end else if (rel_flt_r && retry_done) begin
				rel_flt_r <= 1'b0; // R05
			end
			if (oc_seen && state_r == S_ON) begin
				oc_flt_r <= 1'b1; // R06
			end else if (!over_current) begin
				oc_flt_r <= 1'b0;
			end
			if (undervoltage_fall_threshold) begin
				uv_lock_r <= 1'b1; // R13
			end else if (undervoltage_rise_threshold) begin
				uv_lock_r <= 1'b0; // R13
			end
			int_lim_r <= !limit_set_resistor_ok; // R12
		end
	end

	// ----------------------------------------
	// Switch state machine
	// ----------------------------------------
	always @* begin
		state_nxt = state_r;
		case (state_r)
			S_OFF: begin
				if (uv_lock_r) begin
					state_nxt = S_LOCK;
				end else if (abs_flt_r || rel_flt_r) begin
					state_nxt = S_FAULT; // R01
				end else if (enable_in) begin
					state_nxt = S_ON;
				end
			end
			S_ON: begin
				if (uv_lock_r) begin
					state_nxt = S_LOCK; // R13
				end else if (faults_any || (oc_seen && !oc_flt_r)) begin
					state_nxt = S_FAULT; // R01
				end else if (!enable_in) begin
					state_nxt = S_OFF;
				end
			end
			S_FAULT: begin
				if (uv_lock_r) begin
					state_nxt = S_LOCK;
				end else if (!latch_sel && retry_done && !faults_any) begin // R02 R16 R17
					state_nxt = enable_in ? S_ON : S_OFF;
				end
			end
			S_LOCK: begin
				// Enable is honoured only after the supply has recovered.
				if (!uv_lock_r) begin
					state_nxt = S_OFF; // R13
				end
			end
			default: begin
				state_nxt = S_OFF;
			end
		endcase
		if (load_dump) begin
			state_nxt = state_r; // R15
		end
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			state_r <= S_OFF;
		end else begin
			state_r <= state_nxt;
		end
	end

	assign switch_on = state_r[1];
	assign sense_fault = state_r[2]; // R07

	// ----------------------------------------
	// Current limit foldback
	// ----------------------------------------
	always @(posedge aclk) begin
		if (!aresetn) begin
			fold_cnt_r <= `CNT_RST;
			clean_r <= 1'b0;
			half_r <= 1'b0;
		end else begin
			if (state_r != S_ON && state_nxt == S_ON) begin
				clean_r <= 1'b1;
			end else if (fault_entry) begin
				clean_r <= 1'b0;
			end
			if (standby_in || (state_r == S_ON && state_nxt == S_OFF && clean_r)) begin
				fold_cnt_r <= `CNT_RST; // R10
			end else if (fault_entry && fold_cnt_r != FOLD_COUNT) begin
				fold_cnt_r <= fold_cnt_r + 4'h1; // R09
			end
			half_r <= fold_en_r && (fold_cnt_r == FOLD_COUNT); // R09 R11
		end
	end

	assign limit_half = half_r;
	assign limit_internal = int_lim_r;

	// ----------------------------------------
	// Interrupts
	// ----------------------------------------
	always @* begin
		irq_ev = `IRQ_RST;
		irq_ev[`IRQ_FAULT] = fault_entry;
		irq_ev[`IRQ_RELEASE] = (state_r == S_FAULT) && (state_nxt != S_FAULT);
		irq_ev[`IRQ_UV] = (state_r != S_LOCK) && (state_nxt == S_LOCK);
		irq_ev[`IRQ_FOLD] = fold_en_r && !half_r && (fold_cnt_r == FOLD_COUNT);
		irq_clr = `IRQ_RST;
		if (do_write && awaddr_r == `OFS_IRQ_CLR && wstrb_r[0]) begin
			irq_clr = wdata_r[`IRQ_W-1:0];
		end
	end

	// A new event in the clearing cycle survives the clear.
	always @(posedge aclk) begin
		if (!aresetn) begin
			irq_stat_r <= `IRQ_RST;
			irq_r <= 1'b0;
		end else begin
			irq_stat_r <= (irq_stat_r & ~irq_clr) | irq_ev;
			irq_r <= |(irq_stat_r & irq_en_r);
		end
	end

	assign irq = irq_r;

	// ----------------------------------------
	// AXI4-Lite write side
	// ----------------------------------------
	assign do_write = aw_got_r && w_got_r && !bvalid_r;
	assign wr_ok = (awaddr_r == `OFS_CTRL) || (awaddr_r == `OFS_IRQ_CLR) || (awaddr_r == `OFS_IRQ_EN);

	always @(posedge aclk) begin
		if (!aresetn) begin
			aw_got_r <= 1'b0;
			w_got_r <= 1'b0;
			awaddr_r <= 5'h00;
			wdata_r <= `DATA_ZERO;
			wstrb_r <= 4'h0;
			awready_r <= 1'b0;
			wready_r <= 1'b0;
			bvalid_r <= 1'b0;
			bresp_r <= `RESP_OKAY;
			fold_en_r <= `CTRL_RST;
			irq_en_r <= `IRQ_RST;
		end else begin
			awready_r <= !aw_got_r && !(s_axi_awvalid && awready_r) && !bvalid_r;
			wready_r <= !w_got_r && !(s_axi_wvalid && wready_r) && !bvalid_r;
			if (s_axi_awvalid && awready_r) begin
				aw_got_r <= 1'b1;
				awaddr_r <= s_axi_awaddr;
			end
			if (s_axi_wvalid && wready_r) begin
				w_got_r <= 1'b1;
				wdata_r <= s_axi_wdata;
				wstrb_r <= s_axi_wstrb;
			end
			if (do_write) begin
				bvalid_r <= 1'b1;
				bresp_r <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
				aw_got_r <= 1'b0;
				w_got_r <= 1'b0;
				if (awaddr_r == `OFS_CTRL && wstrb_r[0]) begin
					fold_en_r <= wdata_r[`CTRL_FOLD_EN];
				end
				if (awaddr_r == `OFS_IRQ_EN && wstrb_r[0]) begin
					irq_en_r <= wdata_r[`IRQ_W-1:0];
				end
			end else if (bvalid_r && s_axi_bready) begin
				bvalid_r <= 1'b0;
			end
		end
	end

	assign s_axi_awready = awready_r;
	assign s_axi_wready = wready_r;
	assign s_axi_bvalid = bvalid_r;
	assign s_axi_bresp = bresp_r;

	// ----------------------------------------
	// AXI4-Lite read side
	// ----------------------------------------
	always @* begin
		rd_mux = `DATA_ZERO;
		rd_ok = 1'b1;
		case (s_axi_araddr)
			`OFS_CTRL: begin
				rd_mux[`CTRL_FOLD_EN] = fold_en_r;
			end
			`OFS_STATUS: begin
				rd_mux[`ST_FAULT] = sense_fault;
				rd_mux[`ST_ABS] = abs_flt_r;
				rd_mux[`ST_REL] = rel_flt_r;
				rd_mux[`ST_OC] = oc_flt_r;
				rd_mux[`ST_ON] = switch_on;
				rd_mux[`ST_HALF] = half_r;
				rd_mux[`ST_UV] = uv_lock_r;
				rd_mux[`ST_INT] = int_lim_r;
				rd_mux[`ST_CNT_HI:`ST_CNT_LO] = fold_cnt_r;
			end
			`OFS_IRQ_STAT: begin
				rd_mux[`IRQ_W-1:0] = irq_stat_r;
			end
			`OFS_IRQ_CLR: begin
				rd_mux = `DATA_ZERO;
			end
			`OFS_IRQ_EN: begin
				rd_mux[`IRQ_W-1:0] = irq_en_r;
			end
			default: begin
				rd_ok = 1'b0;
			end
		endcase
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			arready_r <= 1'b0;
			rvalid_r <= 1'b0;
			rdata_r <= `DATA_ZERO;
			rresp_r <= `RESP_OKAY;
		end else begin
			arready_r <= !rvalid_r && !(s_axi_arvalid && arready_r);
			if (s_axi_arvalid && arready_r) begin
				rvalid_r <= 1'b1;
				rdata_r <= rd_mux;
				rresp_r <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
			end else if (rvalid_r && s_axi_rready) begin
				rvalid_r <= 1'b0;
			end
		end
	end

	assign s_axi_arready = arready_r;
	assign s_axi_rvalid = rvalid_r;
	assign s_axi_rdata = rdata_r;
	assign s_axi_rresp = rresp_r;

endmodule // high_side_fault_supervisor

// ---- test/hsfs_checker_properties.sv ----
// Purpose: Port timing relations of the fault supervisor.
// Assumes: One aclk domain, synchronous active-low aresetn.
// Notes: Bound from the bench top.
`timescale 1ns/10ps
module hsfs_checker #(
	parameter [15:0] RETRY_CYCLES = 16'h0010
) (
	// Clock, reset and inputs
	input wire aclk,
	input wire aresetn,
	input wire enable_in,
	input wire latch_sel,
	input wire fet_over_abs,
	input wire rel_over,
	input wire over_current,
	input wire limit_set_resistor_ok,
	input wire undervoltage_fall_threshold,
	input wire load_dump,
	// Outputs
	input wire switch_on,
	input wire sense_fault,
	input wire limit_internal
);
	// Counting fault cycles catches a release that skips the retry span.
	reg [15:0] fault_cyc_r;
	always @(posedge aclk) begin
		if (!aresetn || !sense_fault)
			fault_cyc_r <= 16'h0000;
		else
			fault_cyc_r <= fault_cyc_r + 16'h0001;
	end
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence s_hot;
		(fet_over_abs || rel_over) && !load_dump && !undervoltage_fall_threshold ##1
			!load_dump && !undervoltage_fall_threshold;
	endsequence
	sequence s_blip;
		switch_on && !over_current && !fet_over_abs && !rel_over && !undervoltage_fall_threshold ##1
			(over_current && enable_in)[*2];
	endsequence
	property p_hot_off;
		s_hot |-> ##1 !switch_on && sense_fault;
	endproperty
	// Six cycles cover the bench's four deglitch cycles plus entry and display of the fault.
	property p_oc_off;
		switch_on ##0 (over_current && enable_in && !load_dump && !undervoltage_fall_threshold)[*6]
			|-> !switch_on && sense_fault;
	endproperty
	property p_blip_on;
		s_blip |-> switch_on;
	endproperty
	property p_sense_off;
		sense_fault |-> !switch_on;
	endproperty
	property p_latch;
		sense_fault && latch_sel && !undervoltage_fall_threshold |=> sense_fault && !switch_on;
	endproperty
	property p_retry;
		sense_fault && !undervoltage_fall_threshold && fault_cyc_r < RETRY_CYCLES - 2 |=> sense_fault;
	endproperty
	property p_uv_off;
		(undervoltage_fall_threshold && !load_dump)[*2] |=> !switch_on;
	endproperty
	property p_dump;
		load_dump |=> $stable(switch_on) && $stable(sense_fault);
	endproperty
	property p_ilim;
		(!load_dump)[*2] ##0 $stable(limit_set_resistor_ok) |-> limit_internal != limit_set_resistor_ok;
	endproperty
	a_hot_off: assert property (p_hot_off) else $error("thermal trip kept switch on");
	a_oc_off: assert property (p_oc_off) else $error("held over-current kept switch on");
	a_blip_on: assert property (p_blip_on) else $error("short blip switched off");
	a_sense_off: assert property (p_sense_off) else $error("fault level with switch on");
	a_latch: assert property (p_latch) else $error("latched fault released");
	a_retry: assert property (p_retry) else $error("release before retry span");
	a_uv_off: assert property (p_uv_off) else $error("switch on under low supply");
	a_dump: assert property (p_dump) else $error("state moved in load dump");
	a_ilim: assert property (p_ilim) else $error("internal limit wrong");
endmodule // hsfs_checker

// ---- test/mcu_model.sv ----
// Purpose: Controller side driving the request pins.
// Assumes: Commands come from the bench on aclk.
// Notes: The first request waits until the supply has ramped.
`timescale 1ns/10ps
module mcu_model (
	// Clock, reset and commands
	input wire aclk,
	input wire aresetn,
	input wire want_on,
	input wire want_latch,
	input wire want_stby,
	input wire supply_ok,
	// Pins
	output reg enable_in = 1'b0,
	output reg latch_sel = 1'b0,
	output reg standby_in = 1'b0
);
	// Only the first ramp gates enable, so later dips still test the lockout.
	reg ramped_r = 1'b0;
	always @(posedge aclk) begin
		ramped_r <= aresetn && (ramped_r || supply_ok);
		enable_in <= aresetn && want_on && ramped_r;
		latch_sel <= want_latch;
		standby_in <= want_stby;
	end
endmodule // mcu_model

// ---- test/high_side_fault_supervisor_tb_top.sv ----
// Purpose: Self-checking bench of the fault supervisor.
// Assumes: Short retry and deglitch counts keep the run brief.
// Notes: Blip lengths and resistor states use a fixed seed.
`timescale 1ns/10ps
`include "fault_supervisor_consts.vh"
module high_side_fault_supervisor_tb_top;
	localparam [15:0] RETRY = 16'h0010;
	localparam int FOLD = 7;
	logic aclk = 1'b0, aresetn = 1'b0, want_on = 1'b0, want_latch = 1'b0, want_stby = 1'b0;
	logic enable_in, latch_sel, standby_in, switch_on, sense_fault, limit_half, limit_internal, irq, b;
	logic fet_over_abs = 1'b0, fet_below_hys = 1'b1, rel_over = 1'b0, over_current = 1'b0, load_dump = 1'b0;
	logic limit_set_resistor_ok = 1'b1, undervoltage_fall_threshold = 1'b0, undervoltage_rise_threshold = 1'b0;
	logic [4:0] s_axi_awaddr = 5'h00, s_axi_araddr = 5'h00;
	logic [31:0] s_axi_wdata = 32'h00000000, s_axi_rdata, rd;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp, rs;
	int fail_count = 0, samples_checked = 0, cyc = 0, i, k, n;
	high_side_fault_supervisor #(.RETRY_CYCLES(RETRY), .DEGLITCH_CYCLES(16'h0004), .FOLD_COUNT(4'h7)) u_dut (.*);
	mcu_model u_mcu (.*, .supply_ok(undervoltage_rise_threshold));
	initial forever #4 aclk = ~aclk;
	always @(posedge aclk) begin
		cyc++;
		if (cyc == 20000) begin
			fail_count++;
			end_of_test();
		end
	end
	function automatic logic exp_half(input int j, input logic en);
		return en && j >= FOLD;
	endfunction
	task automatic chk(input string what, input logic [33:0] seen, input logic [33:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			fail_count++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic settle(input logic on, input logic flt);
		#1;
		for (n = 0; n < 80 && (switch_on !== on || sense_fault !== flt); n++) begin
			@(posedge aclk);
			#1;
		end
		chk("switch_on", switch_on, on);
		chk("sense_fault", sense_fault, flt);
	endtask
	task automatic axi_wr(input logic [4:0] a, input logic [31:0] d);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		rs = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask
	task automatic axi_rd(input logic [4:0] a);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		rd = s_axi_rdata;
		rs = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask
	task automatic stby_pulse;
		@(posedge aclk);
		want_stby <= 1'b1;
		repeat (3) @(posedge aclk);
		want_stby <= 1'b0;
		repeat (3) @(posedge aclk);
	endtask
	task automatic run_faults(input int cnt, input logic en);
		for (int j = 1; j <= cnt; j++) begin
			@(posedge aclk);
			over_current <= 1'b1;
			settle(1'b0, 1'b1);
			@(posedge aclk);
			over_current <= 1'b0;
			settle(1'b1, 1'b0);
			repeat (2) @(posedge aclk);
			#1 chk("limit_half", limit_half, exp_half(j, en));
		end
	endtask
	initial begin
		i = $urandom(25163);
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		undervoltage_rise_threshold <= 1'b1;
		for (i = 0; i < 6; i++) begin
			axi_rd(5'(i * 4));
			chk("reset read", {rs, rd}, {(i == 5) ? `RESP_SLVERR : `RESP_OKAY, `DATA_ZERO});
		end
		axi_wr(`OFS_STATUS, 32'h000000FF);
		chk("ro write", rs, `RESP_SLVERR);
		axi_wr(`OFS_IRQ_EN, 32'hFFFFFFFF);
		axi_rd(`OFS_IRQ_EN);
		chk("irq_en", rd, 32'h0000000F);
		$display("registers done");
		@(posedge aclk);
		want_on <= 1'b1;
		settle(1'b1, 1'b0);
		@(posedge aclk);
		fet_over_abs <= 1'b1;
		fet_below_hys <= 1'b0;
		settle(1'b0, 1'b1);
		@(posedge aclk);
		fet_over_abs <= 1'b0;
		repeat (40) @(posedge aclk);
		#1 chk("hysteresis hold", sense_fault, 1'b1);
		@(posedge aclk);
		want_latch <= 1'b1;
		repeat (3) @(posedge aclk);
		fet_below_hys <= 1'b1;
		repeat (40) @(posedge aclk);
		#1 chk("latched", sense_fault, 1'b1);
		chk("irq", irq, 1'b1);
		@(posedge aclk);
		want_latch <= 1'b0;
		settle(1'b1, 1'b0);
		axi_wr(`OFS_IRQ_EN, 32'h00000000);
		axi_rd(`OFS_IRQ_STAT);
		chk("irq masked", irq, 1'b0);
		chk("irq_stat", rd, 32'h00000003);
		axi_wr(`OFS_IRQ_CLR, 32'h0000000F);
		axi_wr(`OFS_IRQ_EN, 32'h0000000F);
		axi_rd(`OFS_IRQ_STAT);
		chk("irq cleared", {irq, rd}, 34'h0);
		$display("thermal done");
		@(posedge aclk);
		rel_over <= 1'b1;
		repeat (3) @(posedge aclk);
		rel_over <= 1'b0;
		settle(1'b0, 1'b1);
		settle(1'b1, 1'b0);
		chk("retry span", n > RETRY - 6 && n < RETRY + 4, 1'b1);
		for (i = 0; i < 6; i++) begin
			k = (i == 0) ? 3 : 1 + $urandom % 3;
			@(posedge aclk);
			over_current <= 1'b1;
			repeat (k) @(posedge aclk);
			over_current <= 1'b0;
			repeat (3) @(posedge aclk);
			#1 chk("blip", switch_on, 1'b1);
		end
		axi_wr(`OFS_CTRL, 32'h00000001);
		stby_pulse();
		run_faults(FOLD, 1'b1);
		axi_rd(`OFS_STATUS);
		chk("fault count", rd[11:8], 4'h7);
		stby_pulse();
		#1 chk("standby restore", limit_half, 1'b0);
		run_faults(FOLD, 1'b1);
		@(posedge aclk);
		want_on <= 1'b0;
		settle(1'b0, 1'b0);
		repeat (2) @(posedge aclk);
		#1 chk("clean restore", limit_half, 1'b0);
		@(posedge aclk);
		want_on <= 1'b1;
		axi_wr(`OFS_CTRL, 32'h00000000);
		run_faults(FOLD + 1, 1'b0);
		$display("current limit done");
		for (i = 0; i < 8; i++) begin
			b = (i == 0) ? 1'b0 : 1'($urandom % 2);
			@(posedge aclk);
			limit_set_resistor_ok <= b;
			repeat (3) @(posedge aclk);
			#1 chk("limit_internal", limit_internal, !b);
		end
		@(posedge aclk);
		limit_set_resistor_ok <= 1'b1;
		undervoltage_fall_threshold <= 1'b1;
		undervoltage_rise_threshold <= 1'b0;
		settle(1'b0, 1'b0);
		@(posedge aclk);
		undervoltage_fall_threshold <= 1'b0;
		repeat (10) @(posedge aclk);
		#1 chk("lockout", switch_on, 1'b0);
		@(posedge aclk);
		undervoltage_rise_threshold <= 1'b1;
		settle(1'b1, 1'b0);
		axi_rd(`OFS_IRQ_STAT);
		chk("uv event", rd[2], 1'b1);
		@(posedge aclk);
		load_dump <= 1'b1;
		want_on <= 1'b0;
		repeat (6) @(posedge aclk);
		#1 chk("dump hold", switch_on, 1'b1);
		@(posedge aclk);
		load_dump <= 1'b0;
		settle(1'b0, 1'b0);
		$display("supply done");
		end_of_test();
	end
endmodule // high_side_fault_supervisor_tb_top
bind high_side_fault_supervisor hsfs_checker #(.RETRY_CYCLES(RETRY_CYCLES)) u_chk (.*);
